// ==== rtl/ssar_seq.sv ====
// Purpose: scan sequencer, averaging and range detect for a SAR core
// Assumes: core answers conv_start with core_done and a right-justified code
// Notes: soc is asynchronous and synchronised; events are one-cycle pulses
// Behaviour
// - sequential averaging stays on channel until done
// - sequential averaging sums readings, result right-aligned
// - interleaved sum takes one conversion per channel
// - scan with a plain channel: end-of-scan every scan, valid after count
// - all interleaved: end-of-scan only when all valid
// - alternate 8/10-bit or native 12-bit per channel
// - no averaging at alternate resolution
// - range detect below/inside/above/outside raises event
// - low threshold resets to 0x0200
// - high threshold resets to 0x0E00
// - compare final 16-bit result, signed if signed
// - scan list holds 1 to 16 channels, default 2
// - disabled channel consumes no scan time
// - filtered channel 0 uses differential format
// - acquisition dwells at least configured minimum
// - limit event on post-averaging range match
// - saturation event on pre-averaging min/max code
// - filter path refused in single-shot mode
// - sequential sum shifted to fit 16 bits
// - sequential fixed shifted back to 12 bits
// - interleaved sum wraps in 16 bits, undetected
// - one global averaging count, default 2
`timescale 1ns/1ps
module ssar_seq
  import ssar_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic soc,
  input wire logic core_done,
  input wire logic [11:0] core_data,
  output logic conv_sample,
  output logic conv_start,
  output logic [3:0] conv_chan,
  output logic conv_alt,
  output logic conv_alt10,
  output logic conv_diff,
  output logic busy,
  output logic eos_pulse,
  output logic range_pulse,
  output logic sat_pulse
);
  // ==========================================================
  // registers and state
  logic [11:0] ctrl_q;
  logic [3:0] numch_q, avgn_q;
  logic [15:0] low_q, high_q, valid_q;
  logic [4:0] stat_q;
  logic [15:0] chcfg_q [16];
  logic [15:0] result_q [16];
  ssar_state_type state_q;
  logic [3:0] ch_q;
  logic [7:0] acq_q, sc_q, ilv_q;
  logic [19:0] sum_q;
  logic [11:0] raw_q;
  logic run_q, plain_seen_q, soc_s1_q, soc_s2_q, soc_s3_q;

  function automatic logic [4:0] first_en(input logic [4:0] from, input logic [3:0] last,
                                          input logic [15:0] en);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (i >= from && i <= last && en[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] code_max(input logic alternate_resolution_select, input logic alt10);
    return alternate_resolution_select ? (alt10 ? 12'h3FF : 12'h0FF) : 12'hFFF;
  endfunction

  // offset-binary code to right-justified 16-bit word
  function automatic logic [15:0] fmt(input logic [11:0] raw, input logic alternate_resolution_select,
                                      input logic alt10, input logic sgn);
    logic [11:0] m;
    logic [11:0] top;
    m = raw & code_max(alternate_resolution_select, alt10);
    top = (code_max(alternate_resolution_select, alt10) >> 1) + 12'h001;
    if (!sgn) begin
      return {4'h0, m};
    end
    return (m & top) != 12'h000 ? {4'h0, m & ~top} : {4'h0, m} - {4'h0, top};
  endfunction

  // ==========================================================
  // APB access
  logic wr_en, rd_en, hit;
  logic [3:0] widx;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign widx = paddr[5:2];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_comb begin
    hit = 1'b1;
    prdata = 32'h0000_0000;
    if (paddr[7:6] == ADDR_CHCFG[7:6] && paddr[1:0] == 2'b00) begin
      prdata = {16'h0000, chcfg_q[widx]};
    end else if (paddr[7:6] == ADDR_RESULT[7:6] && paddr[1:0] == 2'b00) begin
      prdata = {16'h0000, result_q[widx]};
    end else begin
      case (paddr)
        ADDR_CTRL: prdata = {20'h0_0000, ctrl_q & ~12'h003};
        ADDR_NUMCH: prdata = {28'h000_0000, numch_q};
        ADDR_AVGN: prdata = {28'h000_0000, avgn_q};
        ADDR_LOW: prdata = {16'h0000, low_q};
        ADDR_HIGH: prdata = {16'h0000, high_q};
        ADDR_STAT: prdata = {27'h000_0000, stat_q[4:1], busy};
        ADDR_VALID: prdata = {16'h0000, valid_q};
        default: hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      numch_q <= NUMCH_RST;
      avgn_q <= AVGN_RST;
      low_q <= LOW_RST;
      high_q <= HIGH_RST;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: ctrl_q <= pwdata[11:0];
        ADDR_NUMCH: numch_q <= pwdata[3:0];
        ADDR_AVGN: avgn_q <= pwdata[3:0] > AVGN_MAX ? AVGN_MAX : pwdata[3:0];
        ADDR_LOW: low_q <= pwdata[15:0];
        ADDR_HIGH: high_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        chcfg_q[i] <= CHCFG_RST;
      end
    end else if (wr_en && paddr[7:6] == ADDR_CHCFG[7:6]) begin
      chcfg_q[widx] <= pwdata[15:0];
    end
  end

  // ==========================================================
  // trigger
  logic sw_start, sw_stop, cont, filt, soc_rise, go, start_ok;
  logic [11:0] ctrl_v;
  assign sw_start = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_START];
  assign sw_stop = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_STOP];
  // a start written together with new mode bits obeys those bits
  assign ctrl_v = wr_en && paddr == ADDR_CTRL ? pwdata[11:0] : ctrl_q;
  assign cont = ctrl_v[CTRL_CONT];
  assign filt = ctrl_v[CTRL_FILT];
  assign soc_rise = soc_s2_q && !soc_s3_q;
  assign go = sw_start || (ctrl_q[CTRL_SOCEN] && (cont ? soc_s2_q : soc_rise));
  assign start_ok = !(filt && !cont);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soc_s1_q <= 1'b0;
      soc_s2_q <= 1'b0;
      soc_s3_q <= 1'b0;
    end else begin
      soc_s1_q <= soc;
      soc_s2_q <= soc_s1_q;
      soc_s3_q <= soc_s2_q;
    end
  end

  // ==========================================================
  // per-sample datapath
  logic [15:0] en_vec, cfg, fv, fin;
  logic [8:0] cnt;
  logic [3:0] shift;
  logic alternate_resolution_select, diffc, sgn, avg_on, ilv, seq_avg, last_smp, final_c, valid_c, plain_c, sat_c;
  logic [19:0] new_sum;
  logic signed [19:0] sum_ash;
  logic [4:0] nxt, first;
  logic scan_start, scan_end, eos_c, match;
  ssar_avg_type avgm;
  ssar_cmp_type cmpm;

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      en_vec[i] = chcfg_q[i][CH_EN];
    end
  end

  assign avgm = ssar_avg_type'(ctrl_q[CTRL_AVGM +: 2]);
  assign cmpm = ssar_cmp_type'(ctrl_q[CTRL_CMP +: 2]);
  assign cnt = 9'h001 << avgn_q;
  assign cfg = chcfg_q[ch_q];
  assign alternate_resolution_select = cfg[CH_ALT];
  assign diffc = cfg[CH_DIFF] || (ch_q == 4'h0 && filt);
  assign sgn = diffc ? ctrl_q[CTRL_DSGN] : ctrl_q[CTRL_SSGN];
  assign avg_on = cfg[CH_AVG] && !alternate_resolution_select;
  assign ilv = avg_on && avgm == AVG_ILV_SUM;
  assign seq_avg = avg_on && !ilv;
  assign last_smp = {1'b0, sc_q} == cnt - 9'h001;
  assign fv = fmt(raw_q, alternate_resolution_select, ctrl_q[CTRL_ALT10], sgn);
  assign new_sum = sum_q + {{4{fv[15]}}, fv};
  // kept apart so a mixed-sign select cannot turn the shift logical
  assign sum_ash = $signed(new_sum) >>> shift;
  assign shift = avgm == AVG_SEQ_FIX ? avgn_q : (avgn_q > 4'h4 ? avgn_q - 4'h4 : 4'h0);
  assign sat_c = raw_q == 12'h000 || raw_q == code_max(alternate_resolution_select, ctrl_q[CTRL_ALT10]);

  always_comb begin
    fin = fv;
    final_c = 1'b1;
    valid_c = 1'b1;
    if (seq_avg) begin
      // signed shift keeps averaged signed results signed
      fin = 16'(sgn ? sum_ash : new_sum >> shift);
      final_c = last_smp;
    end else if (ilv) begin
      fin = ilv_q == 8'h00 ? fv : result_q[ch_q] + fv;
      valid_c = {1'b0, ilv_q} == cnt - 9'h001;
    end
  end

  always_comb begin
    logic lo, hi;
    lo = sgn ? $signed(fin) < $signed(low_q) : fin < low_q;
    hi = sgn ? $signed(fin) >= $signed(high_q) : fin >= high_q;
    case (cmpm)
      CMP_BELOW: match = lo;
      CMP_INSIDE: match = !lo && !hi;
      CMP_ABOVE: match = hi;
      CMP_OUTSIDE: match = lo || hi;
      default: match = 1'b0;
    endcase
  end

  assign plain_c = !ilv;
  assign first = first_en(5'h00, numch_q, en_vec);
  assign nxt = first_en({1'b0, ch_q} + 5'h01, numch_q, en_vec);
  assign scan_start = state_q == SQ_IDLE && go && start_ok;
  assign scan_end = (state_q == SQ_STORE && final_c && !nxt[4]) || (scan_start && !first[4]);
  // a scan of only interleaved channels reports once per full average
  assign eos_c = plain_seen_q || (state_q == SQ_STORE && plain_c) ||
                 {1'b0, ilv_q} == cnt - 9'h001 || avgm != AVG_ILV_SUM;

  // ==========================================================
  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SQ_IDLE;
      ch_q <= 4'h0;
      acq_q <= 8'h00;
      sc_q <= 8'h00;
      sum_q <= 20'h0_0000;
      raw_q <= 12'h000;
    end else begin
      case (state_q)
        SQ_IDLE: begin
          if (scan_start && first[4]) begin
            ch_q <= first[3:0];
            acq_q <= 8'h00;
            sc_q <= 8'h00;
            sum_q <= 20'h0_0000;
            state_q <= SQ_ACQ;
          end
        end
        SQ_ACQ: begin
          acq_q <= acq_q + 8'h01;
          if (conv_start) begin
            state_q <= SQ_CONV;
          end
        end
        SQ_CONV: begin
          if (core_done) begin
            raw_q <= core_data;
            state_q <= SQ_STORE;
          end
        end
        SQ_STORE: begin
          acq_q <= 8'h00;
          if (!final_c) begin
            sum_q <= new_sum;
            sc_q <= sc_q + 8'h01;
            state_q <= SQ_ACQ;
          end else if (nxt[4]) begin
            ch_q <= nxt[3:0];
            sc_q <= 8'h00;
            sum_q <= 20'h0_0000;
            state_q <= SQ_ACQ;
          end else if ((cont && run_q) || (cont && ctrl_q[CTRL_SOCEN] && soc_s2_q)) begin
            ch_q <= first[3:0];
            sc_q <= 8'h00;
            sum_q <= 20'h0_0000;
            state_q <= first[4] ? SQ_ACQ : SQ_IDLE;
          end else begin
            state_q <= SQ_IDLE;
          end
        end
        default: state_q <= SQ_IDLE;
      endcase
    end
  end

  // continuous run flag and interleave scan counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      ilv_q <= 8'h00;
      plain_seen_q <= 1'b0;
    end else begin
      if (sw_stop) begin
        run_q <= 1'b0;
      end else if (sw_start && cont && start_ok) begin
        run_q <= 1'b1;
      end
      if (scan_end) begin
        plain_seen_q <= 1'b0;
        if (avgm == AVG_ILV_SUM) begin
          ilv_q <= {1'b0, ilv_q} == cnt - 9'h001 ? 8'h00 : ilv_q + 8'h01;
        end
      end else if (state_q == SQ_STORE && plain_c) begin
        plain_seen_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // results, valid flags, sticky status
  logic rd_result;
  assign rd_result = rd_en && paddr[7:6] == ADDR_RESULT[7:6];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        result_q[i] <= 16'h0000;
      end
    end else if (state_q == SQ_STORE && final_c) begin
      result_q[ch_q] <= fin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        // a store in the read cycle keeps the flag set
        if (state_q == SQ_STORE && final_c && valid_c && ch_q == 4'(i)) begin
          valid_q[i] <= 1'b1;
        end else if (rd_result && widx == 4'(i)) begin
          valid_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 5'h00;
      eos_pulse <= 1'b0;
      range_pulse <= 1'b0;
      sat_pulse <= 1'b0;
    end else begin
      eos_pulse <= scan_end && eos_c;
      range_pulse <= state_q == SQ_STORE && final_c && valid_c && cfg[CH_LIM] && match;
      sat_pulse <= state_q == SQ_STORE && cfg[CH_SAT] && sat_c;
      for (int b = 1; b < 5; b++) begin
        if (wr_en && paddr == ADDR_STAT && pwdata[b]) begin
          stat_q[b] <= 1'b0;
        end
      end
      if (scan_end && eos_c) stat_q[ST_EOS] <= 1'b1;
      if (state_q == SQ_STORE && final_c && valid_c && cfg[CH_LIM] && match) begin
        stat_q[ST_RANGE] <= 1'b1;
      end
      if (state_q == SQ_STORE && cfg[CH_SAT] && sat_c) stat_q[ST_SAT] <= 1'b1;
      if (state_q == SQ_IDLE && go && !start_ok) stat_q[ST_FERR] <= 1'b1;
      stat_q[ST_BUSY] <= 1'b0;
    end
  end

  // ==========================================================
  // core drive
  logic [7:0] acq_min;
  assign acq_min = cfg[CH_ACQ +: 8] == 8'h00 ? 8'h01 : cfg[CH_ACQ +: 8];
  assign conv_sample = state_q == SQ_ACQ;
  assign conv_start = state_q == SQ_ACQ && acq_q + 8'h01 >= acq_min;
  assign conv_chan = ch_q;
  assign conv_alt = alternate_resolution_select;
  assign conv_alt10 = ctrl_q[CTRL_ALT10];
  assign conv_diff = diffc;
  assign busy = state_q != SQ_IDLE;

  // ==========================================================
  // checks
  property p_acq_dwell;
    @(posedge pclk) disable iff (!presetn)
    conv_start |-> acq_q + 8'h01 >= acq_min;
  endproperty
  a_acq_dwell: assert property (p_acq_dwell) else $error("acquisition too short");
  property p_en_only;
    @(posedge pclk) disable iff (!presetn)
    conv_start |-> en_vec[conv_chan] && conv_chan <= numch_q;
  endproperty
  a_en_only: assert property (p_en_only) else $error("disabled channel converted");
  property p_seq_stay;
    @(posedge pclk) disable iff (!presetn)
    state_q == SQ_STORE && seq_avg && !last_smp |=> state_q == SQ_ACQ && $stable(ch_q);
  endproperty
  a_seq_stay: assert property (p_seq_stay) else $error("left averaged channel early");
  property p_alt_noavg;
    @(posedge pclk) disable iff (!presetn) state_q == SQ_STORE && alternate_resolution_select |-> final_c && fin == fv;
  endproperty
  a_alt_noavg: assert property (p_alt_noavg) else $error("alternate channel averaged");
  property p_filter_single;
    @(posedge pclk) disable iff (!presetn) filt && !cont && state_q == SQ_IDLE |=> !busy;
  endproperty
  a_filter_single: assert property (p_filter_single) else $error("filter in single shot");
  property p_ilv_eos;
    @(posedge pclk) disable iff (!presetn)
    scan_end && !eos_c |=> !eos_pulse;
  endproperty
  a_ilv_eos: assert property (p_ilv_eos) else $error("early end of scan");
  property p_eos_every;
    @(posedge pclk) disable iff (!presetn)
    scan_end && plain_seen_q |=> eos_pulse;
  endproperty
  a_eos_every: assert property (p_eos_every) else $error("end of scan missing");
  property p_range;
    @(posedge pclk) disable iff (!presetn)
    state_q == SQ_STORE && final_c && valid_c && cfg[CH_LIM] && cmpm == CMP_ABOVE &&
    (sgn ? $signed(fin) >= $signed(high_q) : fin >= high_q) |=> range_pulse;
  endproperty
  a_range: assert property (p_range) else $error("range event missing");
  property p_sat;
    @(posedge pclk) disable iff (!presetn)
    state_q == SQ_STORE && cfg[CH_SAT] && raw_q == 12'h000 |=> sat_pulse ##1 !sat_pulse;
  endproperty
  a_sat: assert property (p_sat) else $error("saturation event wrong");
  c_scan: cover property (@(posedge pclk) disable iff (!presetn) eos_pulse);
  c_seq_avg: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == SQ_STORE && seq_avg && last_smp);
  c_ilv_done: cover property (@(posedge pclk) disable iff (!presetn)
    state_q == SQ_STORE && ilv && valid_c);
endmodule // ssar_seq

// ==== rtl/ssar_pkg.sv ====
// Purpose: shared constants and types for the scanning converter sequencer
// Assumes: APB register map, byte addresses, 32-bit data
// Notes: per-channel windows are word arrays starting at the base offsets
package ssar_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_NUMCH = 8'h04;
  localparam logic [7:0] ADDR_AVGN = 8'h08;
  localparam logic [7:0] ADDR_LOW = 8'h0C;
  localparam logic [7:0] ADDR_HIGH = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_VALID = 8'h18;
  localparam logic [7:0] ADDR_CHCFG = 8'h40;
  localparam logic [7:0] ADDR_RESULT = 8'h80;
  // ==========================================================
  // control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_AVGM = 3;
  localparam int CTRL_ALT10 = 5;
  localparam int CTRL_CMP = 6;
  localparam int CTRL_DSGN = 8;
  localparam int CTRL_SSGN = 9;
  localparam int CTRL_FILT = 10;
  localparam int CTRL_SOCEN = 11;
  // channel config fields
  localparam int CH_EN = 0;
  localparam int CH_ALT = 1;
  localparam int CH_DIFF = 2;
  localparam int CH_AVG = 3;
  localparam int CH_LIM = 4;
  localparam int CH_SAT = 5;
  localparam int CH_ACQ = 8;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_EOS = 1;
  localparam int ST_RANGE = 2;
  localparam int ST_SAT = 3;
  localparam int ST_FERR = 4;
  // ==========================================================
  // reset values and averaging limit
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [3:0] NUMCH_RST = 4'h1;
  localparam logic [3:0] AVGN_RST = 4'h1;
  localparam logic [3:0] AVGN_MAX = 4'h8;
  localparam logic [15:0] LOW_RST = 16'h0200;
  localparam logic [15:0] HIGH_RST = 16'h0E00;
  localparam logic [15:0] CHCFG_RST = 16'h0100;
  // ==========================================================
  typedef enum logic [1:0] {
    AVG_SEQ_SUM = 2'b00, AVG_SEQ_FIX = 2'b01, AVG_ILV_SUM = 2'b10
  } ssar_avg_type;
  typedef enum logic [1:0] {
    CMP_BELOW = 2'b00, CMP_INSIDE = 2'b01, CMP_ABOVE = 2'b10, CMP_OUTSIDE = 2'b11
  } ssar_cmp_type;
  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0001, SQ_ACQ = 4'b0010, SQ_CONV = 4'b0100, SQ_STORE = 4'b1000
  } ssar_state_type;
endpackage

// ==== test/ssar_core_model.sv ====
// Purpose: converter core stand-in answering conv_start with a code
// Assumes: one conversion in flight, latency set by lat
// Notes: code returned is code plus channel number
`timescale 1ns/1ps
module ssar_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_start,
  input wire logic [3:0] conv_chan,
  input wire logic [3:0] lat,
  input wire logic [11:0] code,
  output logic core_done,
  output logic [11:0] core_data
);
  // ==========================================================
  // answer lat+1 cycles after conv_start
  logic [4:0] cnt_q;
  logic [3:0] ch_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      ch_q <= 4'h0;
      core_done <= 1'b0;
      core_data <= 12'h0a5;
    end else begin
      if (conv_start) begin
        cnt_q <= {1'b0, lat} + 5'h01;
        ch_q <= conv_chan;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
      core_done <= (cnt_q == 5'h01);
      // data only meaningful with done; otherwise keep it moving
      if (cnt_q == 5'h01) begin
        core_data <= code + {8'h00, ch_q};
      end else begin
        core_data <= ~core_data;
      end
    end
  end
endmodule // ssar_core_model

// ==== test/sar_scan_averaging_range_detect_bench.sv ====
// Purpose: self-checking bench for the scan sequencer
// Assumes: zero-wait APB, core stand-in on the far side
// Notes: soc stays low; scans are started from software only
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module sar_scan_averaging_range_detect_bench import ssar_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, soc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic core_done, conv_sample, conv_start, conv_alt, conv_alt10, conv_diff;
  logic busy, eos_pulse, range_pulse, sat_pulse, er, alt_seen, diff_seen;
  logic [11:0] core_data, code;
  logic [3:0] conv_chan, lat;
  logic [63:0] chs;
  int errors, checks, nconv, neos, nrng, nsat, acq_n, acq_min;
  // ==========================================================
  // instances
  ssar_seq u_ssar_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .soc(soc), .core_done(core_done), .core_data(core_data),
    .conv_sample(conv_sample), .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_alt(conv_alt), .conv_alt10(conv_alt10), .conv_diff(conv_diff), .busy(busy),
    .eos_pulse(eos_pulse), .range_pulse(range_pulse), .sat_pulse(sat_pulse));
  ssar_core_model u_ssar_core_model (.pclk(pclk), .presetn(presetn),
    .conv_start(conv_start), .conv_chan(conv_chan), .lat(lat), .code(code),
    .core_done(core_done), .core_data(core_data));
  // ==========================================================
  // monitor: pulses are one cycle, so count them at every edge
  always @(posedge pclk) begin
    if (conv_sample === 1'b1) acq_n++;
    if (conv_start === 1'b1) begin
      nconv++;
      chs = {chs[59:0], conv_chan};
      alt_seen = conv_alt;
      diff_seen = conv_diff;
      if (acq_n < acq_min) acq_min = acq_n;
      acq_n = 0;
    end
    if (eos_pulse === 1'b1) neos++;
    if (range_pulse === 1'b1) nrng++;
    if (sat_pulse === 1'b1) nsat++;
  end
  // ==========================================================
  // bus and scan helpers
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(n, e, rd)
  endtask
  task automatic scan(input logic [31:0] c);
    int n;
    nconv = 0; neos = 0; nrng = 0; nsat = 0; chs = '0; acq_min = 99;
    apb(1'b1, ADDR_CTRL, c | 32'h0000_0001);
    n = 0;
    while ((busy !== 1'b0 || n < 3) && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      test_done();
    end
    repeat (2) @(posedge pclk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_ilv();
    apb(1'b1, ADDR_NUMCH, 32'h0000_0001);
    apb(1'b1, ADDR_CHCFG, 32'h0000_0109);
    apb(1'b1, ADDR_CHCFG + 8'h04, 32'h0000_0109);
    scan(32'h0000_0010);
    `CHK("ilv conv", 2, nconv)
    `CHK("ilv eos1", 0, neos)
    rchk("ilv valid1", ADDR_VALID, 32'h0000_0000);
    scan(32'h0000_0010);
    `CHK("ilv eos2", 1, neos)
    rchk("ilv valid2", ADDR_VALID, 32'h0000_0003);
    rchk("ilv res0", ADDR_RESULT, 32'h0000_0246);
    rchk("ilv res1", ADDR_RESULT + 8'h04, 32'h0000_0248);
  endtask
  task automatic t_basic();
    lat <= 4'h3;
    apb(1'b1, ADDR_NUMCH, 32'h0000_0002);
    apb(1'b1, ADDR_CHCFG, 32'h0000_0301);
    apb(1'b1, ADDR_CHCFG + 8'h04, 32'h0000_0100);
    apb(1'b1, ADDR_CHCFG + 8'h08, 32'h0000_0301);
    scan(32'h0000_0000);
    `CHK("skip conv", 2, nconv)
    `CHK("skip order", 64'h2, chs)
    `CHK("acq dwell", 1'b1, acq_min >= 3)
    rchk("res2", ADDR_RESULT + 8'h08, 32'h0000_0125);
    apb(1'b1, ADDR_CHCFG + 8'h08, 32'h0000_0100);
  endtask
  task automatic t_avg();
    lat <= 4'h0;
    apb(1'b1, ADDR_NUMCH, 32'h0000_0001);
    apb(1'b1, ADDR_AVGN, 32'h0000_0002);
    apb(1'b1, ADDR_CHCFG, 32'h0000_0109);
    apb(1'b1, ADDR_CHCFG + 8'h04, 32'h0000_0101);
    scan(32'h0000_0000);
    `CHK("seq conv", 5, nconv)
    `CHK("seq order", 64'h1, chs)
    rchk("seq sum", ADDR_RESULT, 32'h0000_048C);
    rchk("seq plain", ADDR_RESULT + 8'h04, 32'h0000_0124);
    scan(32'h0000_0008);
    rchk("seq fixed", ADDR_RESULT, 32'h0000_0123);
  endtask
  task automatic t_alt();
    code <= 12'hABC;
    apb(1'b1, ADDR_NUMCH, 32'h0000_0000);
    apb(1'b1, ADDR_CHCFG, 32'h0000_010B);
    scan(32'h0000_0000);
    `CHK("alt conv", 1, nconv)
    `CHK("alt flag", 1'b1, alt_seen)
    rchk("alt8", ADDR_RESULT, 32'h0000_00BC);
    scan(32'h0000_0020);
    `CHK("alt10 flag", 1'b1, conv_alt10)
    rchk("alt10", ADDR_RESULT, 32'h0000_02BC);
  endtask
  task automatic t_range();
    logic [11:0] cv [3];
    logic [3:0] em [3];
    cv = '{12'h1FF, 12'h200, 12'hE00};
    em = '{4'b1001, 4'b0010, 4'b1100};
    apb(1'b1, ADDR_CHCFG, 32'h0000_0111);
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 4; m++) begin
        code <= cv[i];
        scan(32'(m) << 6);
        `CHK("range", em[i][m], nrng == 1)
      end
    end
    // signed zero code reads as most negative, so not above high
    code <= 12'h000;
    scan(32'h0000_0280);
    `CHK("range signed", 1'b0, nrng == 1)
    rchk("signed res", ADDR_RESULT, 32'h0000_F800);
  endtask
  task automatic t_sat();
    logic [11:0] cv [3];
    logic ex [3];
    cv = '{12'hFFF, 12'h000, 12'h7FF};
    ex = '{1'b1, 1'b1, 1'b0};
    apb(1'b1, ADDR_CHCFG, 32'h0000_0121);
    for (int i = 0; i < 3; i++) begin
      code <= cv[i];
      scan(32'h0000_0000);
      `CHK("sat", ex[i], nsat == 1)
    end
  endtask
  task automatic t_filt();
    scan(32'h0000_0400);
    `CHK("filt conv", 0, nconv)
    apb(1'b0, ADDR_STAT, 32'h0000_0000);
    `CHK("filt flag", 1'b1, rd[4])
    apb(1'b1, ADDR_STAT, 32'h0000_0010);
    apb(1'b0, ADDR_STAT, 32'h0000_0000);
    `CHK("filt clear", 1'b0, rd[4])
  endtask
  task automatic t_cont();
    int n;
    nconv = 0;
    neos = 0;
    code <= 12'h000;
    apb(1'b1, ADDR_CHCFG, 32'h0000_0101);
    apb(1'b1, ADDR_CTRL, 32'h0000_0505);
    repeat (30) @(posedge pclk);
    apb(1'b1, ADDR_CTRL, 32'h0000_0506);
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    `CHK("cont eos", 1'b1, neos > 2)
    `CHK("cont stop", 1'b0, busy)
    `CHK("filt diff", 1'b1, diff_seen)
    rchk("filt res", ADDR_RESULT, 32'h0000_F800);
  endtask
  // ==========================================================
  // clock and main sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; soc = 1'b0; lat = 4'h0; code = 12'h123;
    errors = 0; checks = 0; acq_n = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("low", ADDR_LOW, 32'h0000_0200);
    rchk("high", ADDR_HIGH, 32'h0000_0E00);
    rchk("numch", ADDR_NUMCH, 32'h0000_0001);
    rchk("avgn", ADDR_AVGN, 32'h0000_0001);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    `CHK("unmapped", 1'b1, er)
    t_ilv();
    t_basic();
    t_avg();
    t_alt();
    t_range();
    t_sat();
    t_filt();
    t_cont();
    test_done();
  end
endmodule // sar_scan_averaging_range_detect_bench
